// ==== rtl/accel_power_mode_control.sv ====
// Purpose: power-mode sequencer with rate selection and autosleep
// Assumes: register port driven by serial decoder on REF_CLK; supply pins asynchronous
// Notes: period of code c is base period shifted left by (15 - c)
module accel_power_mode_control #(
  parameter int TURNON_CYC = accel_pwr_pkg::TURNON_CYCLES, // settle after entry
  parameter int BASE_PERIOD_CYC = accel_pwr_pkg::BASE_PERIOD_CYCLES, // 3200 Hz period
  parameter int SECOND_CYC = accel_pwr_pkg::SECOND_CYCLES // inactivity time unit
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic MAIN_SUPPLY_OK,
  input wire logic IO_SUPPLY_OK,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] ACCEL_MAG,
  output logic [7:0] REG_RDATA,
  output logic SENSE_EN,
  output logic SAMPLE_STROBE,
  output logic [1:0] MODE,
  output logic [3:0] ACTIVE_RATE,
  output logic LOW_POWER_ACTIVE,
  output logic BUFFER_HOLD
);

  // ----------------------------------------------------------------
  // supply pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] main_sync_ff; // bit 0 feeds only bit 1
  logic [1:0] io_sync_ff;
  logic supplies_ok; // both rails present

  // two flops per pin, the first stage is read by nothing else
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      main_sync_ff <= 2'b00;
      io_sync_ff <= 2'b00;
    end else begin
      main_sync_ff <= {main_sync_ff[0], MAIN_SUPPLY_OK};
      io_sync_ff <= {io_sync_ff[0], IO_SUPPLY_OK};
    end
  end
  assign supplies_ok = main_sync_ff[1] & io_sync_ff[1];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] thresh_ff, nxt_thresh; // inactivity_threshold
  logic [7:0] itime_ff, nxt_itime; // inactivity_time
  logic [7:0] rate_ff, nxt_rate; // rate_and_power_select
  logic [7:0] pctl_ff, nxt_pctl; // power_control
  logic [7:0] rdata_ff, nxt_rdata; // read answer

  // writes accepted in every mode so setup can happen in standby
  always_comb begin
    nxt_thresh = thresh_ff;
    nxt_itime = itime_ff;
    nxt_rate = rate_ff;
    nxt_pctl = pctl_ff;
    nxt_rdata = rdata_ff;
    if (REG_WR) begin
      if (REG_ADDR == accel_pwr_pkg::INACT_THRESH_ADDR) begin
        nxt_thresh = REG_WDATA;
      end else if (REG_ADDR == accel_pwr_pkg::INACT_TIME_ADDR) begin
        nxt_itime = REG_WDATA;
      end else if (REG_ADDR == accel_pwr_pkg::RATE_SEL_ADDR) begin
        nxt_rate = REG_WDATA;
      end else if (REG_ADDR == accel_pwr_pkg::PWR_CTL_ADDR) begin
        nxt_pctl = REG_WDATA;
      end
    end
    if (REG_RD) begin
      if (REG_ADDR == accel_pwr_pkg::INACT_THRESH_ADDR) begin
        nxt_rdata = thresh_ff;
      end else if (REG_ADDR == accel_pwr_pkg::INACT_TIME_ADDR) begin
        nxt_rdata = itime_ff;
      end else if (REG_ADDR == accel_pwr_pkg::RATE_SEL_ADDR) begin
        nxt_rdata = rate_ff;
      end else if (REG_ADDR == accel_pwr_pkg::PWR_CTL_ADDR) begin
        nxt_rdata = pctl_ff;
      end else begin
        nxt_rdata = 8'h00; // unmapped reads as zero
      end
    end
  end

  // register storage
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      thresh_ff <= accel_pwr_pkg::INACT_THRESH_RST;
      itime_ff <= accel_pwr_pkg::INACT_TIME_RST;
      rate_ff <= accel_pwr_pkg::RATE_SEL_RST;
      pctl_ff <= accel_pwr_pkg::PWR_CTL_RST;
      rdata_ff <= 8'h00;
    end else begin
      thresh_ff <= nxt_thresh;
      itime_ff <= nxt_itime;
      rate_ff <= nxt_rate;
      pctl_ff <= nxt_pctl;
      rdata_ff <= nxt_rdata;
    end
  end

  // control fields
  logic measure_req; // measurement commanded
  logic sleep_armed; // autosleep and link both set
  logic [3:0] req_code; // requested rate code
  assign measure_req = pctl_ff[accel_pwr_pkg::MEASURE_BIT];
  assign sleep_armed = pctl_ff[accel_pwr_pkg::AUTO_SLEEP_BIT] & pctl_ff[accel_pwr_pkg::LINK_BIT];
  assign req_code = rate_ff[accel_pwr_pkg::RATE_CODE_LSB +: 4];

  // period in cycles for a code, each lower code doubles it
  function automatic logic [31:0] period_of(input logic [3:0] code);
    logic [31:0] base;
    base = 32'(BASE_PERIOD_CYC);
    period_of = base << (accel_pwr_pkg::RATE_CODE_MAX - code);
  endfunction

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  accel_pwr_pkg::pwr_mode_e mode_ff, nxt_mode;
  logic [31:0] cnt_ff, nxt_cnt; // cycles left to next sample
  logic [3:0] code_ff, nxt_code; // rate code in use
  logic lp_ff, nxt_lp; // low power in use
  logic strobe_ff, nxt_strobe; // one-cycle sample pulse
  logic [31:0] sec_ff, nxt_sec; // second prescaler
  logic [7:0] idle_ff, nxt_idle; // whole idle seconds
  logic quiet_ff, nxt_quiet; // last sample at or below threshold
  logic boundary; // current period ends now

  assign boundary = (cnt_ff == 32'h0000_0000);

  // next state of the sequencer and its timers
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cnt = cnt_ff;
    nxt_code = code_ff;
    nxt_lp = lp_ff;
    nxt_strobe = 1'b0;
    nxt_sec = sec_ff;
    nxt_idle = idle_ff;
    nxt_quiet = quiet_ff;
    case (mode_ff)
      accel_pwr_pkg::MODE_STANDBY: begin
        // no sampling here; buffer is simply left untouched
        if (measure_req && supplies_ok) begin
          nxt_mode = accel_pwr_pkg::MODE_STARTUP;
          nxt_code = req_code;
          nxt_lp = rate_ff[accel_pwr_pkg::LOW_PWR_BIT];
          nxt_cnt = period_of(req_code) + 32'(TURNON_CYC);
        end
      end
      accel_pwr_pkg::MODE_STARTUP, accel_pwr_pkg::MODE_MEASURE,
      accel_pwr_pkg::MODE_SLEEP: begin
        if (!boundary) begin
          nxt_cnt = cnt_ff - 32'h0000_0001;
        end else begin
          // a sample completes; new settings only take hold here
          nxt_strobe = 1'b1;
          nxt_quiet = (ACCEL_MAG <= thresh_ff);
          if (mode_ff == accel_pwr_pkg::MODE_SLEEP) begin
            if (ACCEL_MAG > thresh_ff || !sleep_armed) begin
              // activity wakes, and pays the turn-on settle again
              nxt_mode = accel_pwr_pkg::MODE_STARTUP;
              nxt_code = req_code;
              nxt_lp = rate_ff[accel_pwr_pkg::LOW_PWR_BIT];
              nxt_cnt = period_of(req_code) + 32'(TURNON_CYC);
              nxt_idle = 8'h00;
            end else begin
              nxt_cnt = period_of(code_ff) - 32'h0000_0001;
            end
          end else begin
            nxt_mode = accel_pwr_pkg::MODE_MEASURE;
            nxt_code = req_code;
            nxt_lp = rate_ff[accel_pwr_pkg::LOW_PWR_BIT];
            nxt_cnt = period_of(req_code) - 32'h0000_0001;
          end
        end
        // inactivity timer counts whole quiet seconds while measuring
        if (mode_ff == accel_pwr_pkg::MODE_MEASURE) begin
          if (sec_ff == 32'(SECOND_CYC - 1)) begin
            nxt_sec = 32'h0000_0000;
            if (quiet_ff && idle_ff != 8'hff) begin
              nxt_idle = idle_ff + 8'h01;
            end
          end else begin
            nxt_sec = sec_ff + 32'h0000_0001;
          end
          if (!quiet_ff) begin
            nxt_idle = 8'h00;
          end
          if (sleep_armed && itime_ff != 8'h00 && idle_ff >= itime_ff) begin
            nxt_mode = accel_pwr_pkg::MODE_SLEEP;
            nxt_code = accel_pwr_pkg::SLEEP_RATE_CODE;
            nxt_cnt = period_of(accel_pwr_pkg::SLEEP_RATE_CODE) - 32'h0000_0001;
            nxt_idle = 8'h00;
            nxt_sec = 32'h0000_0000;
          end
        end
        // clearing measure or losing a rail stops sampling at once
        if (!measure_req || !supplies_ok) begin
          nxt_mode = accel_pwr_pkg::MODE_STANDBY;
          nxt_strobe = 1'b0;
          nxt_cnt = 32'h0000_0000;
          nxt_idle = 8'h00;
          nxt_sec = 32'h0000_0000;
          nxt_quiet = 1'b0;
        end
      end
      default: begin
        nxt_mode = accel_pwr_pkg::MODE_STANDBY;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_ff <= accel_pwr_pkg::MODE_STANDBY;
      cnt_ff <= 32'h0000_0000;
      code_ff <= 4'h0;
      lp_ff <= 1'b0;
      strobe_ff <= 1'b0;
      sec_ff <= 32'h0000_0000;
      idle_ff <= 8'h00;
      quiet_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      code_ff <= nxt_code;
      lp_ff <= nxt_lp;
      strobe_ff <= nxt_strobe;
      sec_ff <= nxt_sec;
      idle_ff <= nxt_idle;
      quiet_ff <= nxt_quiet;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flop
  // ----------------------------------------------------------------
  logic sense_ff; // sensing powered
  logic hold_ff; // buffer frozen, never cleared here

  // sensing and buffer hold follow the next mode one cycle on
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sense_ff <= 1'b0;
      hold_ff <= 1'b1;
    end else begin
      sense_ff <= (nxt_mode != accel_pwr_pkg::MODE_STANDBY);
      hold_ff <= (nxt_mode == accel_pwr_pkg::MODE_STANDBY);
    end
  end

  assign REG_RDATA = rdata_ff;
  assign SENSE_EN = sense_ff;
  assign SAMPLE_STROBE = strobe_ff;
  assign MODE = mode_ff;
  assign ACTIVE_RATE = code_ff;
  assign LOW_POWER_ACTIVE = lp_ff;
  assign BUFFER_HOLD = hold_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  standby_no_sample_a: assert property (
    (mode_ff == accel_pwr_pkg::MODE_STANDBY) |=> !strobe_ff)
    else $error("sample strobe while in standby");
  measure_entry_a: assert property (
    (mode_ff == accel_pwr_pkg::MODE_STANDBY && measure_req && supplies_ok)
      |=> mode_ff == accel_pwr_pkg::MODE_STARTUP)
    else $error("measure bit did not start sequencing");
  measure_exit_a: assert property (
    (mode_ff != accel_pwr_pkg::MODE_STANDBY && !measure_req)
      |=> mode_ff == accel_pwr_pkg::MODE_STANDBY && !sense_ff)
    else $error("clearing measure did not reach standby");
  // sensing power must track the mode register cycle for cycle
  sense_power_a: assert property (
    sense_ff == (mode_ff != accel_pwr_pkg::MODE_STANDBY))
    else $error("sensing power disagrees with mode");
  reg_write_a: assert property (
    (REG_WR && REG_ADDR == accel_pwr_pkg::PWR_CTL_ADDR) |=> pctl_ff == $past(REG_WDATA))
    else $error("power control write lost");
  read_back_a: assert property (
    (REG_RD && REG_ADDR == accel_pwr_pkg::RATE_SEL_ADDR) |=> REG_RDATA == $past(rate_ff))
    else $error("rate register read wrong");
  rate_steady_a: assert property (
    (mode_ff == accel_pwr_pkg::MODE_MEASURE && !boundary && measure_req && supplies_ok
      && !sleep_armed) |=> $stable(code_ff) && $stable(lp_ff))
    else $error("rate changed inside a sample period");
  first_sample_a: assert property (
    (mode_ff == accel_pwr_pkg::MODE_STANDBY &&
      $past(mode_ff) == accel_pwr_pkg::MODE_STANDBY) ##1
    (mode_ff == accel_pwr_pkg::MODE_STARTUP)
      |-> cnt_ff == period_of(code_ff) + 32'(TURNON_CYC))
    else $error("first sample delay wrong");
  sleep_rate_a: assert property (
    (mode_ff == accel_pwr_pkg::MODE_SLEEP) |-> code_ff == accel_pwr_pkg::SLEEP_RATE_CODE)
    else $error("sleep not at slow rate");
  buffer_kept_a: assert property (
    (mode_ff == accel_pwr_pkg::MODE_STANDBY) [*2] |-> BUFFER_HOLD)
    else $error("buffer not held in standby");

  enter_measure_c: cover property (mode_ff == accel_pwr_pkg::MODE_MEASURE && strobe_ff);
  go_sleep_c: cover property (mode_ff == accel_pwr_pkg::MODE_SLEEP);
  wake_c: cover property (mode_ff == accel_pwr_pkg::MODE_SLEEP
    ##1 mode_ff == accel_pwr_pkg::MODE_STARTUP);
  back_standby_c: cover property (mode_ff == accel_pwr_pkg::MODE_MEASURE
    ##1 mode_ff == accel_pwr_pkg::MODE_STANDBY);

endmodule

// ==== rtl/accel_pwr_pkg.sv ====
// Purpose: shared constants for the acceleration power-mode controller
// Assumes: 125 MHz reference clock, registers reached through the internal register port
// Notes: the serial port decoder sits outside and drives the register port
// Summary of operation
// - power-up enters standby, waits for supplies and command
// - measure bit set moves standby to measurement
// - measure bit cleared returns to standby
// - all registers accessible while in standby
// - sensing off in standby, on when measuring
// - four-bit code selects rate, halving per step
// - low-power bit lowers internal sampling rate; here it only sets LOW_POWER_ACTIVE, sample period unchanged
// - autosleep drops to sub-8 Hz rate on inactivity
// - standby makes no measurements, no new samples
// - entering standby keeps sample buffer contents intact
// - first sample after one period plus 1.1 ms
package accel_pwr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0] INACT_THRESH_ADDR = 6'h25;
  localparam logic [5:0] INACT_TIME_ADDR = 6'h26;
  localparam logic [5:0] RATE_SEL_ADDR = 6'h2c;
  localparam logic [5:0] PWR_CTL_ADDR = 6'h2d;
  // field positions
  localparam int RATE_CODE_LSB = 0;
  localparam int LOW_PWR_BIT = 4;
  localparam int MEASURE_BIT = 3;
  localparam int AUTO_SLEEP_BIT = 4;
  localparam int LINK_BIT = 5;
  // reset values
  localparam logic [7:0] INACT_THRESH_RST = 8'h00;
  localparam logic [7:0] INACT_TIME_RST = 8'h00;
  localparam logic [7:0] RATE_SEL_RST = 8'h0a;
  localparam logic [7:0] PWR_CTL_RST = 8'h00;
  // rate codes
  localparam logic [3:0] RATE_CODE_MAX = 4'hf;
  localparam logic [3:0] SLEEP_RATE_CODE = 4'h6;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real CLK_MHZ = 125.0;
  localparam real TURNON_EXTRA_MS = 1.1;
  localparam real FASTEST_PERIOD_US = 312.5;
  localparam real SECOND_S = 1.0;
  localparam int TURNON_CYCLES = int'($ceil(TURNON_EXTRA_MS * 1000.0 * CLK_MHZ));
  localparam int BASE_PERIOD_CYCLES = int'($floor(FASTEST_PERIOD_US * CLK_MHZ));
  localparam int SECOND_CYCLES = int'($floor(SECOND_S * 1.0e6 * CLK_MHZ));
  // ----------------------------------------------------------------
  // operating modes, gray along standby-startup-measure-sleep
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_STARTUP = 2'b01,
    MODE_MEASURE = 2'b11,
    MODE_SLEEP = 2'b10
  } pwr_mode_e;
endpackage

// ==== dv/accel_host_model.sv ====
// Purpose: host processor model that drives the register port of the power-mode block
// Assumes: one request per call, each strobe held for exactly one edge
// Notes: released address lines carry the inverse of the last value; wr also inverts the data lines, rd leaves them as they were
module accel_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // idle state at time zero
  // --------------------------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end

  // --------------------------------------------------------------
  // bus cycles
  // --------------------------------------------------------------
  // single byte write: strobe taken at the second edge, then lines released
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // single byte read: data is registered, so it is taken once that edge has landed
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ==== dv/accel_power_mode_control_tb.sv ====
// Purpose: self-checking bench for the power-mode sequencer
// Assumes: shortened turn-on, base period and second counts so the run stays short
// Notes: slow rate codes are left out of the random mix, their periods are far too long
module accel_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // shortened timing and bench state
  // --------------------------------------------------------------
  localparam int TURNON = 20; // settle after entry
  localparam int BASE = 8; // fastest sample period
  localparam int SEC = 50; // one idle second
  logic ref_clk, rst, main_ok, io_ok, reg_wr, reg_rd, sense_en, sample_strobe, low_pwr, hold;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, accel_mag, rdv;
  logic [1:0] mode;
  logic [3:0] active_rate, code;
  logic lp;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 91;
  int n;

  accel_power_mode_control #(.TURNON_CYC(TURNON), .BASE_PERIOD_CYC(BASE), .SECOND_CYC(SEC))
    accel_power_mode_control_i (.REF_CLK(ref_clk), .RST(rst), .MAIN_SUPPLY_OK(main_ok),
    .IO_SUPPLY_OK(io_ok), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .ACCEL_MAG(accel_mag), .REG_RDATA(reg_rdata), .SENSE_EN(sense_en),
    .SAMPLE_STROBE(sample_strobe), .MODE(mode), .ACTIVE_RATE(active_rate),
    .LOW_POWER_ACTIVE(low_pwr), .BUFFER_HOLD(hold));

  accel_host_model accel_host_model_i (.clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // sample period in cycles for a rate code, halving the rate per step down
  function automatic int period(input logic [3:0] c);
    return BASE << (15 - int'(c));
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // waits for a strobe (which=0) or a mode (which=1); a spent bound ends the run
  task automatic wait_for(input int which, input logic [1:0] m, input int bound, output int cnt);
    logic hit;
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
      hit = (which == 1) ? (mode === m) : (sample_strobe === 1'b1);
    end while (!hit && cnt < bound);
    if (!hit) begin
      error_cnt++;
      $display("mismatch wait_for%0d expected %b seen %b", which, m, mode);
      finish_test();
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    accel_host_model_i.rd(a, rdv);
    chk("reg_read", rdv, exp);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    main_ok = 1'b1;
    io_ok = 1'b0;
    accel_mag = 8'h10;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("mode_rst", mode, 2'b00);
    chk("sense_rst", sense_en, 1'b0);
    chk("hold_rst", hold, 1'b1);
    // register table reset values, then an unmapped place that must ignore writes
    rdchk(accel_pwr_pkg::INACT_THRESH_ADDR, accel_pwr_pkg::INACT_THRESH_RST);
    rdchk(accel_pwr_pkg::INACT_TIME_ADDR, accel_pwr_pkg::INACT_TIME_RST);
    rdchk(accel_pwr_pkg::RATE_SEL_ADDR, accel_pwr_pkg::RATE_SEL_RST);
    rdchk(accel_pwr_pkg::PWR_CTL_ADDR, accel_pwr_pkg::PWR_CTL_RST);
    accel_host_model_i.wr(6'h10, 8'hff);
    rdchk(6'h10, 8'h00);
    // configure first, then command measuring with the interface supply still absent
    accel_host_model_i.wr(accel_pwr_pkg::RATE_SEL_ADDR, 8'h0f);
    accel_host_model_i.wr(accel_pwr_pkg::PWR_CTL_ADDR, 8'h08);
    repeat (8) @(posedge ref_clk);
    #1;
    chk("mode_no_io", mode, 2'b00);
    @(posedge ref_clk);
    io_ok <= 1'b1;
    wait_for(1, 2'b01, 16, n);
    // two synchroniser edges, then the edge that decodes the command
    chk("io_sync_cycles", n, 3);
    wait_for(0, 2'b00, 1000, n);
    chk("turnon_cycles", n, period(4'hf) + TURNON + 1);
    chk("mode_measure", mode, 2'b11);
    chk("sense_on", sense_en, 1'b1);
    chk("hold_off", hold, 1'b0);
    // random rate codes; low power only within the useful range
    for (int i = 0; i < 8; i++) begin
      code = 4'hb + 4'({$random(seed)} % 5);
      lp = 1'($random(seed)) & (code <= 4'hc);
      accel_host_model_i.wr(accel_pwr_pkg::RATE_SEL_ADDR, {3'b000, lp, code});
      wait_for(0, 2'b00, 300, n);
      chk("active_rate", active_rate, code);
      chk("low_power", low_pwr, lp);
      wait_for(0, 2'b00, 300, n);
      chk("period", n, period(code));
    end
    // back to standby: sensing off, buffer frozen, no sample strobes at all
    accel_host_model_i.wr(accel_pwr_pkg::PWR_CTL_ADDR, 8'h00);
    wait_for(1, 2'b00, 4, n);
    @(posedge ref_clk);
    #1;
    chk("sense_off", sense_en, 1'b0);
    chk("hold_on", hold, 1'b1);
    n = 0;
    repeat (400) begin
      @(posedge ref_clk);
      #1;
      if (sample_strobe === 1'b1) n++;
    end
    chk("standby_strobes", n, 0);
    for (int i = 0; i < 4; i++) begin
      code = 4'(i & 1);
      rdv = 8'($random(seed));
      accel_host_model_i.wr(6'h25 + 6'(code), rdv);
      rdchk(6'h25 + 6'(code), rdv);
    end
    // autosleep: thresholds first, then the sleep and link bits together
    accel_host_model_i.wr(accel_pwr_pkg::INACT_THRESH_ADDR, 8'h40);
    accel_host_model_i.wr(accel_pwr_pkg::INACT_TIME_ADDR, 8'h01);
    accel_host_model_i.wr(accel_pwr_pkg::RATE_SEL_ADDR, 8'h0f); // normal power
    accel_mag <= 8'h40;
    accel_host_model_i.wr(accel_pwr_pkg::PWR_CTL_ADDR, 8'h38);
    wait_for(1, 2'b10, 5000, n);
    chk("sleep_rate", active_rate, accel_pwr_pkg::SLEEP_RATE_CODE);
    // just above the threshold wakes it, through a fresh turn-on at the requested rate
    @(posedge ref_clk);
    accel_mag <= 8'h41;
    wait_for(1, 2'b01, 10000, n);
    wait_for(1, 2'b11, 1000, n);
    chk("wake_rate", active_rate, 4'hf);
    // losing the main rail while measuring drops straight back to standby
    @(posedge ref_clk);
    main_ok <= 1'b0;
    wait_for(1, 2'b00, 8, n);
    chk("main_loss_cycles", n, 3);
    @(posedge ref_clk);
    #1;
    chk("sense_main_loss", sense_en, 1'b0);
    chk("hold_main_loss", hold, 1'b1);
    finish_test();
  end
endmodule
